/* File: rtl/pssl_pkg.sv */
// constants, field layout and state types of the pm serial status link
package pssl_pkg;
  // timing: one microsecond tick from the 100 mhz system clock
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;
  // interval lengths in microsecond ticks, per frequency code
  localparam logic [9:0] IVL_CODE1_US = 10'h001;
  localparam logic [9:0] IVL_CODE2_US = 10'h005;
  localparam logic [9:0] IVL_CODE3_US = 10'h00a;
  // packet framing on the serial line, in system clocks
  localparam logic [2:0] START_CYC = 3'h2;
  localparam logic [2:0] DATA_BITS_M1 = 3'h7;
  localparam logic [2:0] END_CYC = 3'h1;
  // register window in the control space, full addresses of its words
  localparam logic [23:0] WIN_BASE = 24'h008500;
  localparam logic [23:0] WIN_SIZE = 24'h000a00;
  localparam logic [23:0] OFS_SMI = 24'h008500;
  localparam logic [23:0] OFS_CTRL = 24'h008504;
  localparam logic [23:0] OFS_CSTP = 24'h008508;
  localparam logic [23:0] OFS_PKT = 24'h00850c;
  // internal-register addresses reached by the dedicated instructions
  localparam logic [31:0] IREG_BASE_ADDR = 32'h0fffff6c;
  localparam logic [31:0] IREG_MASK_ADDR = 32'hffffff7c;
  // smi status bits
  localparam int SMI_PIN_BIT = 0;
  localparam int SMI_IO_BIT = 1;
  localparam int SMI_MEM_BIT = 2;
  // serial packet control bits
  localparam int VID_EN_BIT = 0;
  localparam int CPU_EN_BIT = 1;
  localparam int CPU_RD_BIT = 2;
  localparam int FREQ_LO_BIT = 3;
  localparam int FREQ_HI_BIT = 4;
  localparam int XTEST_BIT = 5;
  localparam int CSTP_BIT = 0;
  // packet bit positions
  localparam int PKT_VID_BIT = 0;
  localparam int PKT_RANGE_BIT = 1;
  localparam int PKT_CPU_BIT = 2;
  // reset values and sizes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam int PKT_W = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_END = 2'b11
  } pssl_tx_type;

  typedef struct packed {
    logic [2:0] smi;
    logic [4:0] ctrl;
    logic cstp;
    logic [7:0] pkt;
    logic [31:0] base;
    logic [31:0] mask;
    logic [6:0] div;
    logic [9:0] ivl;
    logic send;
    pssl_tx_type tx;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic sout;
    logic [31:0] crd;
    logic crv;
    logic [31:0] ird;
    logic irv;
  } pssl_state_type;
endpackage : pssl_pkg

/* File: rtl/pssl_fifo_if.sv */
// valid/ready carrier between the packet register and the serialiser
`timescale 1ns/1ns
interface pssl_fifo_if #(parameter int W = 8);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport buf_side (input push_valid, input push_data, input pop_ready,
                    output push_ready, output pop_valid, output pop_data);
  modport user_side (output push_valid, output push_data, output pop_ready,
                     input push_ready, input pop_valid, input pop_data);
endinterface : pssl_fifo_if

/* File: rtl/pssl_fifo.sv */
// packet queue between packet capture and the serial transmitter
`timescale 1ns/1ns
module pssl_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input logic clk_sys,
  input logic rst,
  pssl_fifo_if.buf_side q
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } pssl_fifo_state_type;

  pssl_fifo_state_type s_r;
  pssl_fifo_state_type s_nxt;
  logic do_push;
  logic do_pop;

  // flags straight from the occupancy count, so full and empty never lie
  assign q.push_ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign q.pop_valid = (s_r.cnt != '0);
  assign q.pop_data = s_r.mem[s_r.rp];
  assign do_push = q.push_valid && q.push_ready;
  assign do_pop = q.pop_valid && q.pop_ready;

  // pointers wrap naturally since depth is a power of two
  always_comb begin
    s_nxt = s_r;
    if (do_push) begin
      s_nxt.mem[s_r.wp] = q.push_data;
      s_nxt.wp = s_r.wp + AW'(1);
    end
    if (do_pop) begin
      s_nxt.rp = s_r.rp + AW'(1);
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  no_overflow_a: assert property (@(posedge clk_sys) disable iff (rst)
    s_r.cnt == (AW+1)'(DEPTH) |-> !do_push && q.push_ready == 1'b0)
    else $error("fifo accepted a word while full");
  fifo_full_c: cover property (@(posedge clk_sys) disable iff (rst) s_r.cnt == (AW+1)'(DEPTH));
endmodule : pssl_fifo

/* File: rtl/pssl_status_link.sv */
// power management status registers and single-wire event packet transmitter
// Functional notes
// - the event packet register is sent on the status serial output
// - line stays low between packets until the interval counter expires or a test write requests a packet
// - two-clock high start marker when a packet requested at interval expiry or by a test write is sent
// - eight packet bits follow, bit 7 first down to bit 0
// - one-clock high end marker, then line low until the next queued packet starts
// - packet register cleared when its packet is handed to transmission
// - register window spans a00h locations from offset 8500h
// - only four words defined; the rest of the window aliases onto them
// - base and mask reachable only through the internal-register port
// - valid memory address matching base under a nonzero mask sets packet bit 1
// - mask register selects which address bits the range compare uses
// - control register picks the interval and the event enables
// - clock-stop register bit arms the deep low-voltage suspend
// - smi status register reports sticky smm status bits
// - events accumulate into the 8-bit packet between transmissions
`timescale 1ns/1ns
module pssl_status_link
  import pssl_pkg::*;
(
  input logic clk_sys,
  input logic rst,
  input logic [23:0] ctl_addr,
  input logic ctl_wr,
  input logic ctl_rd,
  input logic [31:0] ctl_wdata,
  output logic [31:0] ctl_rdata,
  output logic ctl_rvalid,
  input logic [31:0] ireg_addr,
  input logic ireg_wr,
  input logic ireg_rd,
  input logic [31:0] ireg_wdata,
  output logic [31:0] ireg_rdata,
  output logic ireg_rvalid,
  input logic ev_video,
  input logic ev_cpu_rd_miss,
  input logic ev_cpu_wr_miss,
  input logic mem_valid,
  input logic [31:0] mem_addr,
  input logic smi_pin_ev,
  input logic smi_io_ev,
  input logic smi_mem_ev,
  output logic status_serial_out,
  output logic susp_3v_arm
);
  // block state apart from the packet queue in one packed struct, registered once
  pssl_state_type s_r;
  pssl_state_type s_nxt;
  pssl_fifo_if #(.W(PKT_W)) fq ();

  logic tick;
  logic expire;
  logic [9:0] lim;
  logic [1:0] freq;
  logic in_win;
  logic range_hit;
  logic [7:0] ev;
  logic [7:0] pkt_base;
  logic push;
  logic pop;
  logic xtest;

  pssl_fifo #(.W(PKT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .q(fq.buf_side)
  );

  // queue handshakes; serialiser pulls only when the line is idle
  assign fq.push_valid = s_r.send;
  assign fq.push_data = s_r.pkt;
  assign fq.pop_ready = (s_r.tx == TX_IDLE);
  assign push = fq.push_valid && fq.push_ready;
  assign pop = fq.pop_valid && fq.pop_ready;

  // outputs come straight from the state flops
  assign status_serial_out = s_r.sout;
  assign susp_3v_arm = s_r.cstp;
  assign ctl_rdata = s_r.crd;
  assign ctl_rvalid = s_r.crv;
  assign ireg_rdata = s_r.ird;
  assign ireg_rvalid = s_r.irv;

  // decode helpers
  assign freq = s_r.ctrl[FREQ_HI_BIT:FREQ_LO_BIT];
  assign in_win = (ctl_addr >= WIN_BASE) && (ctl_addr < WIN_BASE + WIN_SIZE);
  assign range_hit = mem_valid && (s_r.mask != RST_WORD) &&
                     (((mem_addr ^ s_r.base) & s_r.mask) == RST_WORD);
  assign tick = (s_r.div == 7'(TICK_CYC - 1));
  assign xtest = ctl_wr && in_win && (ctl_addr[3:2] == OFS_CTRL[3:2]) && ctl_wdata[XTEST_BIT];

  // interval length per frequency code; code zero leaves the timer off
  always_comb begin
    unique case (freq)
      2'h1: lim = IVL_CODE1_US;
      2'h2: lim = IVL_CODE2_US;
      2'h3: lim = IVL_CODE3_US;
      2'h0: lim = IVL_CODE3_US;
    endcase
  end
  // a shorter code written mid-count expires at the next tick instead of wrapping round
  assign expire = tick && (freq != 2'h0) && (s_r.ivl >= lim - 10'h001);

  // enabled cpu and video events plus the range hit
  always_comb begin
    ev = RST_BYTE;
    ev[PKT_VID_BIT] = s_r.ctrl[VID_EN_BIT] && ev_video;
    ev[PKT_CPU_BIT] = s_r.ctrl[CPU_EN_BIT] && (ev_cpu_wr_miss || (s_r.ctrl[CPU_RD_BIT] && ev_cpu_rd_miss));
    ev[PKT_RANGE_BIT] = range_hit;
  end

  // next state of the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.crv = 1'b0;
    s_nxt.irv = 1'b0;
    pkt_base = s_r.pkt;
    // microsecond divider and interval counter
    s_nxt.div = tick ? 7'h00 : s_r.div + 7'h01;
    if (freq == 2'h0) begin
      s_nxt.ivl = 10'h000;
    end else if (tick) begin
      s_nxt.ivl = expire ? 10'h000 : s_r.ivl + 10'h001;
    end
    // an empty packet at expiry is not sent; a test write always is
    if (push) begin
      s_nxt.send = 1'b0;
      pkt_base = RST_BYTE;
    end
    if ((expire && (s_r.pkt != RST_BYTE)) || xtest) begin
      s_nxt.send = 1'b1;
    end
    // register writes; only bits [3:2] decode, so the window aliases
    if (ctl_wr && in_win) begin
      unique case (ctl_addr[3:2])
        OFS_SMI[3:2]: s_nxt.smi = s_r.smi & ~ctl_wdata[2:0];
        OFS_CTRL[3:2]: s_nxt.ctrl = ctl_wdata[4:0];
        OFS_CSTP[3:2]: s_nxt.cstp = ctl_wdata[CSTP_BIT];
        OFS_PKT[3:2]: pkt_base = ctl_wdata[7:0];
      endcase
    end
    // events always land, even in the clearing cycle
    s_nxt.pkt = pkt_base | ev;
    s_nxt.smi[SMI_PIN_BIT] = s_nxt.smi[SMI_PIN_BIT] | smi_pin_ev;
    s_nxt.smi[SMI_IO_BIT] = s_nxt.smi[SMI_IO_BIT] | smi_io_ev;
    s_nxt.smi[SMI_MEM_BIT] = s_nxt.smi[SMI_MEM_BIT] | smi_mem_ev;
    // register reads, answered one clock later; test bit reads zero
    if (ctl_rd && in_win) begin
      s_nxt.crv = 1'b1;
      unique case (ctl_addr[3:2])
        OFS_SMI[3:2]: s_nxt.crd = {29'h0, s_r.smi};
        OFS_CTRL[3:2]: s_nxt.crd = {27'h0, s_r.ctrl};
        OFS_CSTP[3:2]: s_nxt.crd = {31'h0, s_r.cstp};
        OFS_PKT[3:2]: s_nxt.crd = {24'h0, s_r.pkt};
      endcase
    end
    // base and mask live only behind the internal-register port
    if (ireg_wr) begin
      if (ireg_addr == IREG_BASE_ADDR) begin
        s_nxt.base = ireg_wdata;
      end
      if (ireg_addr == IREG_MASK_ADDR) begin
        s_nxt.mask = ireg_wdata;
      end
    end
    // unknown internal addresses read as zero
    if (ireg_rd) begin
      s_nxt.irv = 1'b1;
      s_nxt.ird = (ireg_addr == IREG_BASE_ADDR) ? s_r.base :
                  (ireg_addr == IREG_MASK_ADDR) ? s_r.mask : RST_WORD;
    end
    // serialiser: sout is the level on the line during the current state
    unique case (s_r.tx)
      TX_IDLE: begin
        s_nxt.sout = 1'b0;
        if (pop) begin
          s_nxt.tx = TX_START;
          s_nxt.sh = fq.pop_data;
          s_nxt.cnt = 3'h0;
          s_nxt.sout = 1'b1;
        end
      end
      TX_START: begin
        // line stays high for the whole start marker
        if (s_r.cnt == START_CYC - 3'h1) begin
          s_nxt.tx = TX_DATA;
          s_nxt.cnt = 3'h0;
          s_nxt.sout = s_r.sh[7];
        end else begin
          s_nxt.cnt = s_r.cnt + 3'h1;
          s_nxt.sout = 1'b1;
        end
      end
      TX_DATA: begin
        if (s_r.cnt == DATA_BITS_M1) begin
          s_nxt.tx = TX_END;
          s_nxt.cnt = 3'h0;
          s_nxt.sout = 1'b1;
        end else begin
          s_nxt.sh = {s_r.sh[6:0], 1'b0};
          s_nxt.sout = s_r.sh[6];
          s_nxt.cnt = s_r.cnt + 3'h1;
        end
      end
      TX_END: begin
        // one end clock, then at least one idle low before the next start
        if (s_r.cnt == END_CYC - 3'h1) begin
          s_nxt.tx = TX_IDLE;
          s_nxt.sout = 1'b0;
        end else begin
          s_nxt.cnt = s_r.cnt + 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  frame_shape_a: assert property (pop |=> status_serial_out [*2] ##1 s_r.tx == TX_DATA ##8
    status_serial_out ##1 !status_serial_out)
    else $error("start or end marker wrong");
  msb_first_a: assert property (pop |-> ##3 status_serial_out == $past(fq.pop_data[7], 3))
    else $error("first data bit is not bit 7");
  lsb_last_a: assert property (pop |-> ##10 status_serial_out == $past(fq.pop_data[0], 10))
    else $error("last data bit is not bit 0");
  idle_low_a: assert property (s_r.tx == TX_IDLE && !$past(s_r.tx == TX_END) |-> !status_serial_out)
    else $error("line high while idle");
  pkt_clear_a: assert property (push && !ctl_wr && ev == RST_BYTE |=> s_r.pkt == RST_BYTE)
    else $error("packet not cleared when sent");
  event_kept_a: assert property (push && !ctl_wr && ev != RST_BYTE |=> s_r.pkt == $past(ev))
    else $error("event lost in clearing cycle");
  range_hit_a: assert property (range_hit |=> s_r.pkt[PKT_RANGE_BIT])
    else $error("range hit did not set packet bit 1");
  ireg_only_a: assert property (!ireg_wr |=> $stable(s_r.base) && $stable(s_r.mask))
    else $error("base or mask changed without internal write");
  cstp_arm_a: assert property (ctl_wr && in_win && ctl_addr[3:2] == OFS_CSTP[3:2] |=>
    susp_3v_arm == $past(ctl_wdata[CSTP_BIT]))
    else $error("clock stop enable not taken");
  win_read_a: assert property (ctl_rd |=> ctl_rvalid == $past(in_win))
    else $error("window read answer wrong");
  smi_sticky_a: assert property (smi_pin_ev |=> s_r.smi[SMI_PIN_BIT])
    else $error("smi pin event lost");
  interval_a: assert property (expire && s_r.pkt != RST_BYTE |=> s_r.send)
    else $error("expiry with events did not request a packet");

  // register side: control takes writes, packet word answers, clock stop holds, smi clears, internal port answers
  ctrl_write_a: assert property (ctl_wr && in_win && ctl_addr[3:2] == OFS_CTRL[3:2] |=>
    s_r.ctrl == $past(ctl_wdata[4:0]))
    else $error("control write not taken");
  pkt_read_a: assert property (ctl_rd && in_win && ctl_addr[3:2] == OFS_PKT[3:2] |=>
    ctl_rdata == {24'h000000, $past(s_r.pkt)})
    else $error("packet read answer wrong");
  cstp_hold_a: assert property (!(ctl_wr && in_win && ctl_addr[3:2] == OFS_CSTP[3:2]) |=>
    $stable(susp_3v_arm))
    else $error("clock stop enable changed without a write");
  smi_clear_a: assert property (ctl_wr && in_win && ctl_addr[3:2] == OFS_SMI[3:2] && ctl_wdata[SMI_PIN_BIT] &&
    !smi_pin_ev |=> !s_r.smi[SMI_PIN_BIT])
    else $error("smi status bit not cleared by a one");
  ireg_answer_a: assert property (ireg_rd |=> ireg_rvalid)
    else $error("internal register read not answered");
  ireg_other_a: assert property (ireg_rd && ireg_addr != IREG_BASE_ADDR && ireg_addr != IREG_MASK_ADDR |=>
    ireg_rdata == RST_WORD)
    else $error("unknown internal register read not zero");

  // line timing: one clock per bit and a low clock after every frame
  bit_hold_a: assert property (s_r.tx == TX_DATA && s_r.cnt != DATA_BITS_M1 |=>
    s_r.tx == TX_DATA && s_r.cnt == $past(s_r.cnt) + 3'h1)
    else $error("data bit held for more than one clock");
  frame_gap_a: assert property (s_r.tx == TX_END |=> !status_serial_out)
    else $error("no low clock after end marker");

  // interval and queue: empty packets stay home, a full queue makes a request wait
  empty_skip_a: assert property (expire && s_r.pkt == RST_BYTE && !s_r.send && !xtest |=> !s_r.send)
    else $error("empty packet queued at expiry");
  queue_wait_a: assert property (s_r.send && !fq.push_ready |=> s_r.send)
    else $error("packet request dropped while queue full");
  ivl_bound_a: assert property (s_r.ivl < IVL_CODE3_US)
    else $error("interval counter ran past the longest interval");
  div_range_a: assert property (s_r.div < 7'(TICK_CYC))
    else $error("microsecond divider out of range");
  xtest_send_a: assert property (xtest |=> s_r.send)
    else $error("test write did not request a packet");

  full_frame_c: cover property (pop ##12 s_r.tx == TX_IDLE);
  kept_event_c: cover property (push && ev != RST_BYTE);
  test_send_c: cover property (xtest ##1 push);
  back_to_back_c: cover property (s_r.tx == TX_END ##1 pop);
endmodule : pssl_status_link

/* File: test/pssl_companion_rx.sv */
// companion receiver model: decodes frames seen on the status serial line
`timescale 1ns/1ns
module pssl_companion_rx (
  input logic clk_sys,
  input logic rst,
  input logic line_in,
  output logic [7:0] rx_byte,
  output int rx_count,
  output int rx_errors
);
  int phase;
  logic [7:0] sh;

  // phase 0-1 hunt the start marker, 2-9 data, 10 end marker, 11 idle low
  always @(posedge clk_sys) begin
    if (rst) begin
      phase <= 0;
      rx_count <= 0;
      rx_errors <= 0;
      rx_byte <= 8'h00;
    end else if (phase < 2) begin
      phase <= line_in ? phase + 1 : 0;
    end else if (phase < 10) begin
      sh <= {sh[6:0], line_in};
      phase <= phase + 1;
    end else if (phase == 10) begin
      // a missing end marker is a framing fault; byte handed over here, before any next start
      if (line_in !== 1'b1) begin
        rx_errors <= rx_errors + 1;
      end
      rx_byte <= sh;
      rx_count <= rx_count + 1;
      phase <= 11;
    end else begin
      // the line must fall right after the end marker
      if (line_in !== 1'b0) begin
        rx_errors <= rx_errors + 1;
      end
      phase <= 0;
    end
  end
endmodule : pssl_companion_rx

/* File: test/tb_pssl_status_link.sv */
// self-checking bench for the pm serial status link
`timescale 1ns/1ns
module tb_pssl_status_link;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [23:0] ctl_addr = 24'h000000;
  logic ctl_wr = 1'b0;
  logic ctl_rd = 1'b0;
  logic [31:0] ctl_wdata = 32'h00000000;
  logic [31:0] ctl_rdata;
  logic ctl_rvalid;
  logic [31:0] ireg_addr = 32'h00000000;
  logic ireg_wr = 1'b0;
  logic ireg_rd = 1'b0;
  logic [31:0] ireg_wdata = 32'h00000000;
  logic [31:0] ireg_rdata;
  logic ireg_rvalid;
  logic [6:0] evs = 7'h00; // video, rd miss, wr miss, mem valid, smi pin, smi io, smi mem
  logic [31:0] mem_addr = 32'h00000000;
  logic status_serial_out;
  logic susp_3v_arm;
  logic [7:0] rx_byte;
  int rx_count;
  int rx_errors;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] q;
  bit got;

  pssl_status_link dut (.clk_sys(clk_sys), .rst(rst), .ctl_addr(ctl_addr), .ctl_wr(ctl_wr),
    .ctl_rd(ctl_rd), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .ctl_rvalid(ctl_rvalid),
    .ireg_addr(ireg_addr), .ireg_wr(ireg_wr), .ireg_rd(ireg_rd), .ireg_wdata(ireg_wdata),
    .ireg_rdata(ireg_rdata), .ireg_rvalid(ireg_rvalid), .ev_video(evs[0]), .ev_cpu_rd_miss(evs[1]),
    .ev_cpu_wr_miss(evs[2]), .mem_valid(evs[3]), .mem_addr(mem_addr), .smi_pin_ev(evs[4]),
    .smi_io_ev(evs[5]), .smi_mem_ev(evs[6]), .status_serial_out(status_serial_out),
    .susp_3v_arm(susp_3v_arm));

  pssl_companion_rx rx (.clk_sys(clk_sys), .rst(rst), .line_in(status_serial_out),
    .rx_byte(rx_byte), .rx_count(rx_count), .rx_errors(rx_errors));

  // 100 mhz system clock
  always #5 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // one access on either port; strobe lasts one clock, answer seen one clock later
  task automatic acc(input bit ir, input bit wr, input logic [31:0] a, input logic [31:0] d);
    got = 1'b0;
    q = 32'hxxxxxxxx;
    @(negedge clk_sys);
    if (ir) begin
      ireg_addr = a;
      ireg_wdata = d;
      ireg_wr = wr;
      ireg_rd = !wr;
    end else begin
      ctl_addr = a[23:0];
      ctl_wdata = d;
      ctl_wr = wr;
      ctl_rd = !wr;
    end
    @(negedge clk_sys);
    {ireg_wr, ireg_rd, ctl_wr, ctl_rd} = 4'h0;
    if ((ir ? ireg_rvalid : ctl_rvalid) === 1'b1) begin
      got = 1'b1;
      q = ir ? ireg_rdata : ctl_rdata;
    end
  endtask : acc

  task automatic rd(input bit ir, input logic [31:0] a, input logic [31:0] exp, input string what);
    acc(ir, 1'b0, a, 32'h00000000);
    check(what, q, exp);
  endtask : rd

  // event inputs are one-clock pulses
  task automatic pulse(input int b);
    @(negedge clk_sys);
    evs[b] = 1'b1;
    @(negedge clk_sys);
    evs[b] = 1'b0;
  endtask : pulse

  // bounded wait for the receiver to count n frames
  task automatic wait_rx(input int n, input logic [7:0] exp);
    for (int i = 0; i < 1500 && rx_count < n; i++) @(negedge clk_sys);
    check("rx_count", 32'(rx_count), 32'(n));
    check("rx_byte", {24'h000000, rx_byte}, {24'h000000, exp});
    check("line idle", {31'h0, status_serial_out}, 32'h00000000);
  endtask : wait_rx

  // watchdog, far beyond the roughly 1600 cycles the tests need
  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) rd(0, 32'h00008500 + 32'(4 * i), 32'h00000000, "reset reg");
    rd(1, 32'h0fffff6c, 32'h00000000, "base reset");
    rd(1, 32'hffffff7c, 32'h00000000, "mask reset");
    $display("test reset values done");
    acc(0, 1, 32'h00008504, 32'h00000007);
    rd(0, 32'h00008504, 32'h00000007, "control");
    rd(0, 32'h00008ef4, 32'h00000007, "alias");
    acc(0, 0, 32'h00008f04, 32'h00000000);
    check("outside answer", {31'h0, got}, 32'h00000000);
    check("outside data", ctl_rdata, 32'h00000007);
    acc(0, 1, 32'h00008508, 32'h00000001);
    check("arm", {31'h0, susp_3v_arm}, 32'h00000001);
    rd(0, 32'h00008508, 32'h00000001, "clock stop");
    acc(0, 1, 32'h00008508, 32'h00000000);
    acc(1, 1, 32'h0fffff6c, 32'h12345000);
    acc(1, 1, 32'hffffff7c, 32'hfffff000);
    rd(1, 32'h0fffff6c, 32'h12345000, "base");
    rd(1, 32'hffffff7c, 32'hfffff000, "mask");
    rd(1, 32'h0fffff70, 32'h00000000, "ireg other");
    $display("test registers done");
    acc(0, 1, 32'h00008504, 32'h00000000);
    pulse(0);
    rd(0, 32'h0000850c, 32'h00000000, "video off");
    acc(0, 1, 32'h00008504, 32'h00000001);
    pulse(0);
    rd(0, 32'h0000850c, 32'h00000001, "video on");
    mem_addr = 32'h12345abc;
    pulse(3);
    rd(0, 32'h0000850c, 32'h00000003, "range hit");
    acc(0, 1, 32'h00008504, 32'h00000007);
    pulse(1);
    rd(0, 32'h0000850c, 32'h00000007, "cpu read");
    acc(0, 1, 32'h00008504, 32'h0000000f);
    wait_rx(1, 8'h07);
    acc(0, 1, 32'h00008504, 32'h00000000);
    rd(0, 32'h0000850c, 32'h00000000, "cleared");
    $display("test interval frame done");
    acc(0, 1, 32'h0000850c, 32'h000000a5);
    acc(0, 1, 32'h00008504, 32'h00000021);
    evs[0] = 1'b1; // lands in the very cycle the packet enters the queue
    @(negedge clk_sys);
    evs[0] = 1'b0;
    rd(0, 32'h0000850c, 32'h00000001, "kept event");
    rd(0, 32'h00008504, 32'h00000001, "send bit");
    acc(0, 1, 32'h00008504, 32'h00000020);
    wait_rx(2, 8'ha5);
    wait_rx(3, 8'h01);
    rd(0, 32'h0000850c, 32'h00000000, "cleared");
    $display("test send now done");
    // slower interval codes: nothing may leave before the interval has run out
    for (int k = 2; k < 4; k++) begin
      acc(0, 1, 32'h0000850c, 32'(8'h3c + k));
      acc(0, 1, 32'h00008504, 32'(k << 3));
      repeat (k == 2 ? 380 : 880) @(negedge clk_sys);
      check("early frame", 32'(rx_count), 32'(k + 1));
      wait_rx(k + 2, 8'(8'h3c + k));
      acc(0, 1, 32'h00008504, 32'h00000000);
    end
    $display("test interval codes done");
    pulse(4);
    pulse(5);
    pulse(6);
    rd(0, 32'h00008500, 32'h00000007, "smi");
    acc(0, 1, 32'h00008500, 32'h00000005);
    rd(0, 32'h00008500, 32'h00000002, "smi clear");
    check("frame faults", 32'(rx_errors), 32'h00000000);
    $display("test smi done");
    give_verdict();
  end
endmodule : tb_pssl_status_link
